// ===== hw/crt_video_extension_pkg.sv
// Purpose: constants for the extended video control register bank
// Assumes: registers reached by index through the graphics index/data port
// Notes:   offsets are register indexes, not byte addresses
package crt_video_extension_pkg;
  localparam logic [7:0] VIDEO_SELECT_IDX         = 8'h0c;
  localparam logic [7:0] CRT_LOCK_CONTROL_IDX     = 8'h0d;
  localparam logic [7:0] VIDEO_OUTPUT_CONTROL_IDX = 8'h0e;
  localparam logic [7:0] UNLOCK_IDX               = 8'h0f;
  localparam logic [3:0] UNLOCK_NIBBLE            = 4'h5;
  localparam logic [7:0] REG_RESET                = 8'h00;
  // video_select fields
  localparam int VS_MAP_SELECT  = 5;
  localparam int VS_CLK_PERIOD  = 3;
  localparam int VS_UNDERLINE   = 2;
  localparam int VS_CLK_SELECT  = 1;
  localparam int VS_FORCE_CLOCK = 0;
  // crt_lock_control fields
  localparam int LK_VSYNC_POL   = 7;
  localparam int LK_HSYNC_POL   = 6;
  localparam int LK_HORIZ       = 5;
  localparam int LK_ADDR_BIT9   = 4;
  localparam int LK_ADDR_BIT8   = 3;
  localparam int LK_SCAN_DOUBLE = 2;
  localparam int LK_PREVENT     = 1;
  localparam int LK_VERT        = 0;
  // video_output_control fields
  localparam int VO_BLANK_FUNC  = 7;
  localparam int VO_PCLK_SELECT = 6;
  localparam int VO_VIDEO_TRI   = 5;
  localparam int VO_MEM_TRI     = 4;
  localparam int VO_CGA_FORCE   = 3;
  localparam int VO_EGA_COMPAT  = 1;
  // Character clock codes and widths
  localparam logic [1:0] CLK_STANDARD = 2'b00;
  localparam logic [1:0] CLK_SEVEN    = 2'b01;
  localparam logic [1:0] CLK_NINE     = 2'b10;
  localparam logic [1:0] CLK_TEN      = 2'b11;
  localparam logic [3:0] DOTS_SEVEN   = 4'h7;
  localparam logic [3:0] DOTS_EIGHT   = 4'h8;
  localparam logic [3:0] DOTS_NINE    = 4'h9;
  localparam logic [3:0] DOTS_TEN     = 4'ha;
  localparam logic [3:0] PAN_ZERO_CODE = 4'h9;
  localparam logic [3:0] PAN_ONE_CODE  = 4'h8;
  localparam logic [3:0] PAN_OFFSET    = 4'h2;
  // Character map planes
  localparam logic [1:0] PLANE_TWO   = 2'h2;
  localparam logic [1:0] PLANE_THREE = 2'h3;
  // CRT register indexes, lock masks and protect bit
  localparam logic [7:0] CRT_HTIMING_LAST = 8'h05;
  localparam logic [7:0] CRT_VTOTAL       = 8'h06;
  localparam logic [7:0] CRT_OVERFLOW     = 8'h07;
  localparam logic [7:0] CRT_MAX_SCAN     = 8'h09;
  localparam logic [7:0] CRT_VRET_START   = 8'h10;
  localparam logic [7:0] CRT_VRET_END     = 8'h11;
  localparam logic [7:0] CRT_VBLANK_START = 8'h15;
  localparam logic [7:0] CRT_VBLANK_END   = 8'h16;
  localparam logic [7:0] CRT_MODE_CTRL    = 8'h17;
  localparam logic [7:0] OVF_GROUP1_MASK  = 8'h42;
  localparam logic [7:0] OVF_GROUP2_MASK  = 8'had;
  localparam logic [7:0] MAXSCAN_G3_MASK  = 8'h20;
  localparam logic [7:0] VRET_G3_MASK     = 8'h0f;
  localparam logic [7:0] MODE_G4_MASK     = 8'h04;
  localparam int         VRET_PROTECT     = 7;
endpackage : crt_video_extension_pkg

// ===== hw/crt_video_extension_regs.sv
// Purpose: extended video select, CRT lock and output control registers
// Assumes: host port decode already picked the graphics index/data pair
// Notes:   strap input crosses from a pin; three-stage sampled
module crt_video_extension_regs
  import crt_video_extension_pkg::*;
(
  input  wire logic       sys_clk,
  input  wire logic       reset_n,
  input  wire logic       clk_en,
  // Indexed register port
  input  wire logic [7:0] reg_index,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_write,
  input  wire logic       reg_read,
  output logic      [7:0] reg_rdata,
  // Host CRT register write request, filtered here
  input  wire logic [7:0] crt_index,
  input  wire logic [7:0] crt_wdata,
  input  wire logic [7:0] crt_old_data,
  input  wire logic       crt_write,
  input  wire logic       crt_vret_protect,
  output logic            crt_write_strobe,
  output logic      [7:0] crt_write_data,
  // Sync polarity write
  input  wire logic       polarity_write,
  input  wire logic [1:0] polarity_wdata,
  output logic      [1:0] sync_polarity,
  // Read qualification
  input  wire logic       read_is_ega_writeonly,
  output logic            read_blocked,
  // Character and attribute path
  input  wire logic       page_mode_addressing,
  input  wire logic       attribute_bit_four,
  input  wire logic [7:0] attribute_code,
  input  wire logic       graphics_mode,
  input  wire logic       standard_nine_dots,
  input  wire logic [3:0] pel_panning,
  output logic      [1:0] map_plane,
  output logic            map_plane_valid,
  output logic      [3:0] char_width,
  output logic      [3:0] pan_shift,
  output logic            underline_en,
  output logic            background_bit_three,
  // Clocking
  input  wire logic       config_strap_three,
  input  wire logic       sequencer_half_clock,
  input  wire logic       dot_clock_derived,
  input  wire logic       video_clock_in,
  output logic            third_clock_select_line,
  output logic            clock_mux_freeze,
  output logic            horiz_half_clock,
  output logic            pixel_clock_out,
  // Address and scan
  input  wire logic [4:0] cursor_start,
  input  wire logic [4:0] cursor_stop,
  input  wire logic [4:0] preset_row_scan,
  input  wire logic [4:0] max_scan_line,
  output logic      [1:0] character_address_high,
  output logic      [5:0] eff_cursor_start,
  output logic      [5:0] eff_cursor_stop,
  output logic      [5:0] eff_preset_row_scan,
  output logic      [5:0] eff_max_scan_line,
  // Output control
  input  wire logic       blank_in,
  input  wire logic       display_enable_in,
  output logic            blanking_output,
  output logic            video_out_enable,
  output logic            memory_out_enable,
  input  wire logic       cga_alpha_80x25,
  input  wire logic       cga_enable_video,
  output logic            cga_enable_video_eff,
  output logic            shift_256_color
);

  logic [7:0] video_select_reg;
  logic [7:0] crt_lock_reg;
  logic [7:0] video_output_ctrl_reg;
  logic [2:0] unlock_reg;
  logic [2:0] strap_sync;
  logic       strap_stable;

  logic unlocked;
  logic wr_video_select;
  logic wr_crt_lock;
  logic wr_output_ctrl;
  logic protect;
  logic lock_horiz;
  logic lock_vert;

  assign protect  = crt_vret_protect;
  assign unlocked = (unlock_reg == UNLOCK_NIBBLE[2:0]);
  assign wr_video_select = clk_en && reg_write && unlocked
                           && reg_index == VIDEO_SELECT_IDX;
  assign wr_crt_lock     = clk_en && reg_write && unlocked
                           && reg_index == CRT_LOCK_CONTROL_IDX;
  assign wr_output_ctrl  = clk_en && reg_write && unlocked
                           && reg_index == VIDEO_OUTPUT_CONTROL_IDX;

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
      unlock_reg <= 3'h0;
    else if (clk_en && reg_write && reg_index == UNLOCK_IDX)
      unlock_reg <= reg_wdata[2:0];
  end

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      video_select_reg      <= REG_RESET;
      crt_lock_reg          <= REG_RESET;
      video_output_ctrl_reg <= REG_RESET;
    end
    else
    begin
      if (wr_video_select)
        video_select_reg <= reg_wdata;
      if (wr_crt_lock)
        crt_lock_reg <= reg_wdata;
      if (wr_output_ctrl)
        video_output_ctrl_reg <= reg_wdata;
    end
  end

  // Strap comes from a pin; only agreeing later stages are used
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      strap_sync   <= 3'h0;
      strap_stable <= 1'b0;
    end
    else if (clk_en)
    begin
      strap_sync <= {strap_sync[1:0], config_strap_three};
      if (strap_sync[1] == strap_sync[2])
        strap_stable <= strap_sync[2];
    end
  end

  assign read_blocked = video_output_ctrl_reg[VO_EGA_COMPAT] && read_is_ega_writeonly;

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
      reg_rdata <= 8'h00;
    else if (clk_en && reg_read)
    begin
      unique case (reg_index)
        VIDEO_SELECT_IDX:         reg_rdata <= video_select_reg;
        CRT_LOCK_CONTROL_IDX:     reg_rdata <= crt_lock_reg;
        VIDEO_OUTPUT_CONTROL_IDX: reg_rdata <= video_output_ctrl_reg;
        UNLOCK_IDX:               reg_rdata <= {5'h00, unlock_reg};
        default:                  reg_rdata <= 8'h00;
      endcase
      if (video_output_ctrl_reg[VO_EGA_COMPAT])
        reg_rdata <= 8'h00;
    end
  end

  // CRT write filter: per-bit mask of protected bits
  assign lock_horiz = crt_lock_reg[LK_HORIZ];
  assign lock_vert  = crt_lock_reg[LK_VERT];
  logic [7:0] locked_mask;
  always_comb
  begin
    locked_mask = 8'h00;
    if (crt_index <= CRT_HTIMING_LAST && (lock_horiz || protect))
      locked_mask = 8'hff;
    if (crt_index == CRT_VTOTAL && (lock_vert || protect))
      locked_mask = 8'hff;
    if (crt_index == CRT_OVERFLOW)
    begin
      if (!crt_lock_reg[LK_PREVENT] && protect)
        locked_mask = locked_mask | OVF_GROUP1_MASK;
      if (lock_vert || protect)
        locked_mask = locked_mask | OVF_GROUP2_MASK;
    end
    if (lock_vert)
    begin
      if (crt_index == CRT_MAX_SCAN)
        locked_mask = MAXSCAN_G3_MASK;
      if (crt_index == CRT_VRET_START || crt_index == CRT_VBLANK_START
          || crt_index == CRT_VBLANK_END)
        locked_mask = 8'hff;
      if (crt_index == CRT_VRET_END)
        locked_mask = VRET_G3_MASK;
    end
    if (crt_index == CRT_MODE_CTRL && lock_horiz)
      locked_mask = MODE_G4_MASK;
  end

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      crt_write_strobe <= 1'b0;
      crt_write_data   <= 8'h00;
    end
    else if (clk_en)
    begin
      crt_write_strobe <= crt_write;
      crt_write_data   <= (crt_wdata & ~locked_mask) | (crt_old_data & locked_mask);
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
      sync_polarity <= 2'b00;
    else if (clk_en && polarity_write)
    begin
      if (!crt_lock_reg[LK_VSYNC_POL])
        sync_polarity[1] <= polarity_wdata[1];
      if (!crt_lock_reg[LK_HSYNC_POL])
        sync_polarity[0] <= polarity_wdata[0];
    end
  end

  // Character path
  logic [1:0] clk_code;
  assign clk_code = video_select_reg[VS_CLK_PERIOD +: 2];
  always_comb
  begin
    if (!video_select_reg[VS_MAP_SELECT])
      map_plane = PLANE_TWO;
    else if (!video_select_reg[VS_UNDERLINE])
      map_plane = PLANE_THREE;
    else
      map_plane = attribute_bit_four ? PLANE_THREE : PLANE_TWO;
    map_plane_valid = !page_mode_addressing;
    unique case (clk_code)
      CLK_STANDARD: char_width = standard_nine_dots ? DOTS_NINE : DOTS_EIGHT;
      CLK_SEVEN:    char_width = DOTS_SEVEN;
      CLK_NINE:     char_width = DOTS_NINE;
      CLK_TEN:      char_width = DOTS_TEN;
    endcase
    if (graphics_mode)
      char_width = DOTS_EIGHT;
    if (clk_code == CLK_TEN && !graphics_mode)
    begin
      if (pel_panning == PAN_ZERO_CODE)
        pan_shift = 4'h0;
      else if (pel_panning == PAN_ONE_CODE)
        pan_shift = 4'h1;
      else
        pan_shift = 4'(pel_panning + PAN_OFFSET);
    end
    else
      pan_shift = pel_panning;
  end

  assign underline_en = video_select_reg[VS_UNDERLINE] && attribute_code[0];
  assign background_bit_three = video_select_reg[VS_UNDERLINE] ? 1'b0 : attribute_code[7];

  assign third_clock_select_line = strap_stable && video_select_reg[VS_CLK_SELECT];
  assign clock_mux_freeze = !strap_stable && video_select_reg[VS_CLK_SELECT];
  assign horiz_half_clock = sequencer_half_clock && !video_select_reg[VS_FORCE_CLOCK];
  assign pixel_clock_out = video_output_ctrl_reg[VO_PCLK_SELECT] ? video_clock_in
                                                                 : dot_clock_derived;

  assign character_address_high = {crt_lock_reg[LK_ADDR_BIT9], crt_lock_reg[LK_ADDR_BIT8]};
  assign eff_cursor_start    = crt_lock_reg[LK_SCAN_DOUBLE] ? {cursor_start, 1'b0}
                                                            : {1'b0, cursor_start};
  assign eff_cursor_stop     = crt_lock_reg[LK_SCAN_DOUBLE] ? {cursor_stop, 1'b0}
                                                            : {1'b0, cursor_stop};
  assign eff_preset_row_scan = crt_lock_reg[LK_SCAN_DOUBLE] ? {preset_row_scan, 1'b0}
                                                            : {1'b0, preset_row_scan};
  assign eff_max_scan_line   = crt_lock_reg[LK_SCAN_DOUBLE] ? {max_scan_line, 1'b0}
                                                            : {1'b0, max_scan_line};

  assign blanking_output = video_output_ctrl_reg[VO_BLANK_FUNC] ? display_enable_in : blank_in;
  assign video_out_enable  = !video_output_ctrl_reg[VO_VIDEO_TRI];
  assign memory_out_enable = !video_output_ctrl_reg[VO_MEM_TRI];
  assign cga_enable_video_eff = cga_enable_video
                                || (video_output_ctrl_reg[VO_CGA_FORCE] && cga_alpha_80x25);
  assign shift_256_color = video_output_ctrl_reg[0];

endmodule : crt_video_extension_regs

// ===== verification/crt_video_extension_properties.sv
// Purpose: concurrent checks on the extended video register bank ports
// Assumes: one clock domain, asynchronous active-low reset
// Notes:   a locked CRT bit must come back as crt_old_data
module crt_video_extension_properties
  import crt_video_extension_pkg::*;
(
  input wire logic       sys_clk,
  input wire logic       reset_n,
  input wire logic       clk_en,
  input wire logic [7:0] crt_index,
  input wire logic [7:0] crt_wdata,
  input wire logic [7:0] crt_old_data,
  input wire logic       crt_write,
  input wire logic       crt_vret_protect,
  input wire logic       crt_write_strobe,
  input wire logic [7:0] crt_write_data,
  input wire logic       page_mode_addressing,
  input wire logic       map_plane_valid,
  input wire logic       graphics_mode,
  input wire logic [3:0] char_width,
  input wire logic [3:0] pel_panning,
  input wire logic [3:0] pan_shift,
  input wire logic       underline_en,
  input wire logic       background_bit_three,
  input wire logic [4:0] max_scan_line,
  input wire logic [5:0] eff_max_scan_line
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  logic any_wr;
  logic prot_wr;
  assign any_wr  = clk_en && crt_write;
  assign prot_wr = any_wr && crt_vret_protect;

  property p_strobe; any_wr |=> crt_write_strobe; endproperty
  a_strobe: assert property (p_strobe) else $error("crt write not passed on");
  property p_grp0; prot_wr && crt_index <= CRT_HTIMING_LAST |=> crt_write_data == $past(crt_old_data);
  endproperty
  a_grp0: assert property (p_grp0) else $error("horizontal reg written");
  property p_vtot; prot_wr && crt_index == CRT_VTOTAL |=> crt_write_data == $past(crt_old_data);
  endproperty
  a_vtot: assert property (p_vtot) else $error("vertical total written");
  property p_ovf; prot_wr && crt_index == CRT_OVERFLOW |=>
    (crt_write_data & OVF_GROUP2_MASK) == ($past(crt_old_data) & OVF_GROUP2_MASK); endproperty
  a_ovf: assert property (p_ovf) else $error("overflow bits written");
  property p_free; any_wr && crt_index == CRT_OVERFLOW |=>
    ((crt_write_data ^ $past(crt_wdata)) & 8'h10) == 8'h00; endproperty
  a_free: assert property (p_free) else $error("free overflow bit lost");
  property p_pan; char_width == DOTS_TEN && pel_panning <= 4'h7 |-> pan_shift == pel_panning + 4'h2;
  endproperty
  a_pan: assert property (p_pan) else $error("ten dot pan shift wrong");
  property p_pan0; char_width == DOTS_TEN && pel_panning == PAN_ZERO_CODE |-> pan_shift == 4'h0;
  endproperty
  a_pan0: assert property (p_pan0) else $error("pan code nine not zero");
  property p_gfx; graphics_mode |-> char_width == DOTS_EIGHT; endproperty
  a_gfx: assert property (p_gfx) else $error("width changed in graphics");
  property p_page; page_mode_addressing |-> !map_plane_valid; endproperty
  a_page: assert property (p_page) else $error("plane select in page mode");
  property p_ul; underline_en |-> !background_bit_three; endproperty
  a_ul: assert property (p_ul) else $error("background bit kept");
  property p_scan; eff_max_scan_line == {1'h0, max_scan_line} ||
    eff_max_scan_line == {max_scan_line, 1'h0}; endproperty
  a_scan: assert property (p_scan) else $error("scan value neither kept nor doubled");
  c_prot: cover property (prot_wr);
  c_pan: cover property (char_width == DOTS_TEN && pel_panning == PAN_ZERO_CODE);
  c_page: cover property (page_mode_addressing);
endmodule : crt_video_extension_properties

bind crt_video_extension_regs crt_video_extension_properties i_props (.sys_clk, .reset_n,
  .clk_en, .crt_index, .crt_wdata, .crt_old_data, .crt_write, .crt_vret_protect,
  .crt_write_strobe, .crt_write_data, .page_mode_addressing, .map_plane_valid, .graphics_mode,
  .char_width, .pel_panning, .pan_shift, .underline_en, .background_bit_three, .max_scan_line,
  .eff_max_scan_line);

// ===== verification/tb.sv
// Purpose: self-checking bench for the extended video register bank
// Assumes: inputs change 1 ns after the rising edge
// Notes:   CRT filter writes mostly use new data ff over old data 00
module tb
  import crt_video_extension_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct {logic [7:0] vs; logic att; logic [3:0] w; logic [1:0] pl;} row_t;
  logic       sys_clk = 1'h0, reset_n = 1'h0, clk_en = 1'h1, reg_write = 1'h0, reg_read = 1'h0;
  logic       crt_write = 1'h0, crt_vret_protect = 1'h0, polarity_write = 1'h0;
  logic       read_is_ega_writeonly = 1'h1, page_mode_addressing = 1'h0, attribute_bit_four = 1'h0;
  logic       graphics_mode = 1'h0, standard_nine_dots = 1'h0, config_strap_three = 1'h1;
  logic       sequencer_half_clock = 1'h1, dot_clock_derived = 1'h0, video_clock_in = 1'h1;
  logic       blank_in = 1'h1, display_enable_in = 1'h0, cga_alpha_80x25 = 1'h1;
  logic       cga_enable_video = 1'h0;
  logic [7:0] reg_index = 8'h00, reg_wdata = 8'h00, crt_index = 8'h00, crt_wdata = 8'hff;
  logic [7:0] crt_old_data = 8'h00, attribute_code = 8'h81, reg_rdata, crt_write_data;
  logic [4:0] cursor_start = 5'h0b, cursor_stop = 5'h0b, preset_row_scan = 5'h0b;
  logic [4:0] max_scan_line = 5'h0b;
  logic [3:0] pel_panning = 4'h0, char_width, pan_shift;
  logic [1:0] polarity_wdata = 2'h0, sync_polarity, map_plane, character_address_high;
  logic       crt_write_strobe, read_blocked, map_plane_valid, underline_en, background_bit_three;
  logic       third_clock_select_line, clock_mux_freeze, horiz_half_clock, pixel_clock_out;
  logic       blanking_output, video_out_enable, memory_out_enable, cga_enable_video_eff;
  logic       shift_256_color;
  logic [5:0] eff_cursor_start, eff_cursor_stop, eff_preset_row_scan, eff_max_scan_line;
  int         fail_count = 0, n_compared = 0;
  row_t       rows [8] = '{'{8'h00, 1'h0, 4'h8, 2'h2}, '{8'h08, 1'h0, 4'h7, 2'h2},
    '{8'h10, 1'h0, 4'h9, 2'h2}, '{8'h18, 1'h0, 4'ha, 2'h2}, '{8'h38, 1'h1, 4'ha, 2'h3},
    '{8'h24, 1'h0, 4'h8, 2'h2}, '{8'h24, 1'h1, 4'h8, 2'h3}, '{8'h04, 1'h1, 4'h8, 2'h2}};

  crt_video_extension_regs i_dut (.sys_clk, .reset_n, .clk_en, .reg_index, .reg_wdata,
    .reg_write, .reg_read, .reg_rdata, .crt_index, .crt_wdata, .crt_old_data, .crt_write,
    .crt_vret_protect, .crt_write_strobe, .crt_write_data, .polarity_write, .polarity_wdata,
    .sync_polarity, .read_is_ega_writeonly, .read_blocked, .page_mode_addressing,
    .attribute_bit_four, .attribute_code, .graphics_mode, .standard_nine_dots, .pel_panning,
    .map_plane, .map_plane_valid, .char_width, .pan_shift, .underline_en, .background_bit_three,
    .config_strap_three, .sequencer_half_clock, .dot_clock_derived, .video_clock_in,
    .third_clock_select_line, .clock_mux_freeze, .horiz_half_clock, .pixel_clock_out,
    .cursor_start, .cursor_stop, .preset_row_scan, .max_scan_line, .character_address_high,
    .eff_cursor_start, .eff_cursor_stop, .eff_preset_row_scan, .eff_max_scan_line, .blank_in,
    .display_enable_in, .blanking_output, .video_out_enable, .memory_out_enable,
    .cga_alpha_80x25, .cga_enable_video, .cga_enable_video_eff, .shift_256_color);

  always #5 sys_clk = ~sys_clk;

  task automatic conclude();
    $display("mismatches %0d of %0d compared", fail_count, n_compared);
    if (fail_count == 0 && n_compared > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : conclude

  task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic cyc();
    @(posedge sys_clk);
    #1;
  endtask : cyc

  task automatic wr(input logic [7:0] i, input logic [7:0] d);
    reg_index = i;
    reg_wdata = d;
    reg_write = 1'h1;
    cyc();
    reg_write = 1'h0;
    // Idle edge so a strobe never re-rises in one step
    cyc();
  endtask : wr

  task automatic rd(input logic [7:0] i, input logic [7:0] e);
    reg_index = i;
    reg_read = 1'h1;
    cyc();
    reg_read = 1'h0;
    chk(reg_rdata, e);
    cyc();
  endtask : rd

  task automatic cw(input logic [7:0] i, input logic [7:0] e);
    crt_index = i;
    crt_write = 1'h1;
    cyc();
    crt_write = 1'h0;
    chk(crt_write_strobe, 1'h1);
    chk(crt_write_data, e);
    cyc();
    chk(crt_write_strobe, 1'h0);
  endtask : cw

  task automatic pw(input logic [1:0] d);
    polarity_wdata = d;
    polarity_write = 1'h1;
    cyc();
    polarity_write = 1'h0;
    cyc();
  endtask : pw

  // Whole run is about 150 cycles
  initial
  begin
    #50us;
    fail_count++;
    conclude();
  end

  initial
  begin
    repeat (10) @(posedge sys_clk);
    #1;
    reset_n = 1'h1;
    rd(VIDEO_SELECT_IDX, REG_RESET);
    wr(VIDEO_SELECT_IDX, 8'hff);
    rd(VIDEO_SELECT_IDX, REG_RESET);
    wr(UNLOCK_IDX, 8'hf5);
    foreach (rows[k])
    begin
      attribute_bit_four = rows[k].att;
      wr(VIDEO_SELECT_IDX, rows[k].vs);
      chk(char_width, rows[k].w);
      chk(map_plane, rows[k].pl);
      chk({underline_en, background_bit_three}, {rows[k].vs[2], !rows[k].vs[2]});
      rd(VIDEO_SELECT_IDX, rows[k].vs);
    end
    wr(VIDEO_SELECT_IDX, 8'h18);
    for (int p = 0; p < 10; p++)
    begin
      pel_panning = 4'(p);
      cyc();
      chk(pan_shift, (p == 9) ? 4'h0 : (p == 8) ? 4'h1 : 4'(p + 2));
    end
    graphics_mode = 1'h1;
    page_mode_addressing = 1'h1;
    cyc();
    chk({char_width, map_plane_valid}, {DOTS_EIGHT, 1'h0});
    graphics_mode = 1'h0;
    page_mode_addressing = 1'h0;
    wr(VIDEO_SELECT_IDX, 8'h03);
    repeat (6) cyc();
    chk({third_clock_select_line, clock_mux_freeze, horiz_half_clock}, 3'h4);
    config_strap_three = 1'h0;
    repeat (6) cyc();
    chk(clock_mux_freeze, 1'h1);
    wr(VIDEO_SELECT_IDX, 8'h00);
    chk({clock_mux_freeze, horiz_half_clock}, 2'h1);
    wr(CRT_LOCK_CONTROL_IDX, 8'h20);
    cw(8'h03, 8'h00);
    cw(CRT_MODE_CTRL, 8'hfb);
    cw(CRT_VRET_START, 8'hff);
    wr(CRT_LOCK_CONTROL_IDX, 8'h01);
    cw(CRT_VRET_START, 8'h00);
    cw(CRT_MAX_SCAN, 8'hdf);
    cw(CRT_VRET_END, 8'hf0);
    cw(CRT_OVERFLOW, 8'h52);
    wr(CRT_LOCK_CONTROL_IDX, 8'h00);
    crt_vret_protect = 1'h1;
    crt_old_data = 8'h0f;
    cw(CRT_HTIMING_LAST, 8'h0f);
    crt_old_data = 8'h00;
    cw(CRT_OVERFLOW, 8'h10);
    cw(CRT_VRET_END, 8'hff);
    wr(CRT_LOCK_CONTROL_IDX, 8'h02);
    cw(CRT_OVERFLOW, 8'h52);
    crt_vret_protect = 1'h0;
    wr(CRT_LOCK_CONTROL_IDX, 8'h1c);
    chk(character_address_high, 2'h3);
    chk({eff_cursor_start, eff_cursor_stop, eff_preset_row_scan, eff_max_scan_line},
      {4{6'h16}});
    wr(CRT_LOCK_CONTROL_IDX, 8'h00);
    pw(2'h3);
    chk(sync_polarity, 2'h3);
    wr(CRT_LOCK_CONTROL_IDX, 8'hc0);
    pw(2'h0);
    chk(sync_polarity, 2'h3);
    wr(CRT_LOCK_CONTROL_IDX, 8'h80);
    pw(2'h0);
    chk(sync_polarity, 2'h2);
    wr(VIDEO_OUTPUT_CONTROL_IDX, 8'h00);
    chk({blanking_output, video_out_enable, memory_out_enable, cga_enable_video_eff,
      pixel_clock_out}, 5'h1c);
    wr(VIDEO_OUTPUT_CONTROL_IDX, 8'hf9);
    chk({blanking_output, video_out_enable, memory_out_enable, cga_enable_video_eff,
      shift_256_color, pixel_clock_out, read_blocked}, 7'h0e);
    video_clock_in = 1'h0;
    cga_alpha_80x25 = 1'h0;
    cyc();
    chk({pixel_clock_out, cga_enable_video_eff}, 2'h0);
    wr(VIDEO_SELECT_IDX, 8'h24);
    wr(VIDEO_OUTPUT_CONTROL_IDX, 8'h02);
    chk(read_blocked, 1'h1);
    rd(VIDEO_SELECT_IDX, 8'h00);
    wr(VIDEO_OUTPUT_CONTROL_IDX, 8'h00);
    rd(VIDEO_SELECT_IDX, 8'h24);
    // Clock enable low must freeze the bank
    clk_en = 1'h0;
    wr(VIDEO_SELECT_IDX, 8'hff);
    clk_en = 1'h1;
    rd(VIDEO_SELECT_IDX, 8'h24);
    rd(8'h30, 8'h00);
    wr(UNLOCK_IDX, 8'h04);
    wr(VIDEO_SELECT_IDX, 8'h20);
    rd(VIDEO_SELECT_IDX, 8'h24);
    reset_n = 1'h0;
    cyc();
    reset_n = 1'h1;
    rd(CRT_LOCK_CONTROL_IDX, REG_RESET);
    conclude();
  end
endmodule : tb
